// *** dv/csc_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module csc_assertions (
  input wire logic       i_clock,
  input wire logic       i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_gate,
  input wire logic [7:0] o_rdata,
  input wire logic       o_osc_enable,
  input wire logic [1:0] o_osc_current_range,
  input wire logic [3:0] o_sense_channel_select,
  input wire logic       o_osc_pad,
  input wire logic       o_second_timer_tick
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire        w0 = i_wr && i_addr == 8'h00;
  wire        w4 = i_wr && i_addr == 8'h04;
  logic [7:0] t1c;
  // A shadow of the second timer control lets gating be judged from the ports alone.
  always @(posedge i_clock or negedge i_rstn)
    if (!i_rstn) t1c <= 8'h00;
    else if (i_wr && i_addr == 8'h0C) t1c <= i_wdata;
  chk_chan_follow: assert property (w4 ##1 !w4 |-> ##1 o_sense_channel_select == $past(i_wdata[3:0], 2))
    else $error("channel select mismatch");
  chk_enable_follow: assert property (w0 ##1 !w0 |-> ##1 o_osc_enable == $past(i_wdata[7], 2))
    else $error("enable mismatch");
  chk_range_follow: assert property (w0 ##1 !w0 |-> ##1 o_osc_current_range == $past(i_wdata[3:2], 2))
    else $error("range mismatch");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside answer");
  chk_unmapped_zero: assert property (i_rd && (i_addr[1:0] != 2'h0 || i_addr > 8'h14) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pad_off: assert property (!o_osc_enable ##1 !o_osc_enable |-> !o_osc_pad)
    else $error("pad driven while disabled");
  chk_timer_off: assert property (!t1c[0] [*6] |-> !o_second_timer_tick)
    else $error("second timer counts while off");
  chk_gate_holds: assert property ((t1c[1:0] == 2'h3 && !i_gate) [*6] |-> !o_second_timer_tick)
    else $error("second timer counts with gate closed");
endmodule // csc_assertions
bind csc_osc_control csc_assertions u_chk (.*);
`default_nettype wire

// *** dv/csc_osc_control_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module csc_osc_control_test;
  logic        i_clock = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_gate = 1'b0;
  logic        i_first_timer_pin_clock = 1'b0, i_second_timer_other_clock = 1'b0, alt_on = 1'b0;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, d;
  logic [15:0] i_sense_inputs = 16'h0000;
  wire logic [7:0] o_rdata;
  wire logic       o_osc_enable, o_osc_pad, o_first_timer_tick, o_second_timer_tick;
  wire logic       i_osc_out, i_osc_direction;
  wire logic [1:0] o_osc_current_range;
  wire logic [3:0] o_sense_channel_select;
  int          num_errors = 0, tests_run = 0, n0 = 0, n1 = 0, a0, a1, k;
  logic [24:0] rows [0:10];
  logic [18:0] cases [0:4];
  always #5 i_clock = ~i_clock;
  always #37 if (alt_on) begin
    i_first_timer_pin_clock = ~i_first_timer_pin_clock;
    i_second_timer_other_clock = ~i_second_timer_other_clock;
  end
  always @(posedge i_clock) begin
    if (o_first_timer_tick) n0 <= n0 + 1;
    if (o_second_timer_tick) n1 <= n1 + 1;
  end
  csc_osc_control u_dut (.*);
  csc_pad_model u_pad (.i_enable(o_osc_enable), .i_range(o_osc_current_range),
    .o_osc_out(i_osc_out), .o_osc_direction(i_osc_direction));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task conclude;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    conclude;
  end
  initial begin
    // Rows: write flag, address, write data, expected read back.
    rows = '{25'h0000000, 25'h0040000, 25'h0080020, 25'h00C0000, 25'h1000F0D, 25'h104FA0A,
             25'h1143333, 25'h10CC3C3, 25'h1105A5A, 25'h122FF00, 25'h1080000};
    // Cases: first timer option, second timer control, gate, whether each timer is expected to tick (bit 1 second, bit 0 first).
    cases = '{19'h10618, 19'h0061F, 19'h10604, 19'h1060A, 19'h1020F};
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    for (k = 0; k < 11; k++) begin
      if (rows[k][24]) wr(rows[k][23:16], rows[k][15:8]);
      rd(rows[k][23:16]);
      chk(d, rows[k][7:0]);
    end
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h8D);
    for (k = 0; k < 16; k++) begin
      i_sense_inputs <= k[0] ? (16'h0001 << k) : ~(16'h0001 << k);
      wr(8'h04, k[7:0]);
      repeat (3) @(posedge i_clock);
      #1 chk({3'h0, o_osc_pad, o_sense_channel_select}, {3'h0, k[0], k[3:0]});
    end
    repeat (2) begin
      @(i_osc_direction);
      repeat (6) @(posedge i_clock);
      rd(8'h00);
      chk(d, {6'h23, i_osc_direction, 1'b1});
    end
    // The time base is the bench's own cycle count, never the timer being clocked.
    for (k = 0; k < 5; k++) begin
      alt_on = (k == 4);
      i_gate <= cases[k][2];
      wr(8'h14, 8'h00);
      wr(8'h08, cases[k][18:11]);
      a0 = n0;
      a1 = n1;
      wr(8'h0C, cases[k][10:3]);
      repeat (400) @(posedge i_clock);
      wr(8'h0C, 8'h00);
      wr(8'h08, 8'h20);
      repeat (6) @(posedge i_clock);
      rd(8'h14);
      chk(d, 8'(n1 - a1));
      chk({6'h0, n1 != a1, n0 != a0}, {6'h0, cases[k][1:0]});
    end
    @(posedge i_clock) i_rstn <= 1'b0;
    #2 chk({o_osc_enable, o_osc_pad, o_osc_current_range, o_sense_channel_select}, 8'h00);
    @(posedge i_clock) i_rstn <= 1'b1;
    rd(8'h04);
    chk(d, 8'h00);
    conclude;
  end
endmodule // csc_osc_control_test
`default_nettype wire

// *** dv/csc_pad_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module csc_pad_model (
  input  wire logic       i_enable,
  input  wire logic [1:0] i_range,
  output var  logic       o_osc_out,
  output wire logic       o_osc_direction
);
  initial o_osc_out = 1'b0;
  // The ramp stalls unless the pad is enabled and driven, as a misconfigured pin would.
  always begin
    wait (i_enable && i_range != 2'h0);
    #(230 * (4 - i_range)) o_osc_out = ~o_osc_out;
  end
  assign o_osc_direction = o_osc_out;
endmodule // csc_pad_model
`default_nettype wire

// *** logic/csc_consts.vh ***
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH
// Register addresses (byte addresses of plain register port).
`define CSC_ADDR_CTRL_FIRST   8'h00
`define CSC_ADDR_CTRL_SECOND  8'h04
`define CSC_ADDR_T0_OPTION    8'h08
`define CSC_ADDR_T1_CONTROL   8'h0C
`define CSC_ADDR_T0_COUNT     8'h10
`define CSC_ADDR_T1_COUNT     8'h14
// First sense control fields.
`define CSC_F1_ENABLE         7
`define CSC_F1_RANGE_LO       2
`define CSC_F1_RANGE_HI       3
`define CSC_F1_DIR            1
`define CSC_F1_T0_SENSE       0
// Second sense control fields.
`define CSC_F2_CH_LO          0
`define CSC_F2_CH_HI          3
// First timer option field.
`define CSC_T0_CS             5
// Second timer control fields.
`define CSC_T1_CS_LO          6
`define CSC_T1_CS_HI          7
`define CSC_T1_GE             1
`define CSC_T1_ON             0
`define CSC_T1_CS_SENSE       2'h3
// Reset values.
`define CSC_RST_CTRL_FIRST    8'h00
`define CSC_RST_CTRL_SECOND   8'h00
`define CSC_RST_T0_OPTION     8'h20
`define CSC_RST_T1_CONTROL    8'h00
`define CSC_NUM_INPUTS        16
`define CSC_RANGE_OFF         2'h0
`endif

// *** logic/csc_osc_control.v ***
// How it works
// RULE_01: Sixteen sense inputs, any one can be routed to the oscillator.
// RULE_02: Four-bit channel select in second control register picks the input.
// RULE_03: Writing a channel while enabled moves the oscillator there at once.
// RULE_04: Software makes the selected pin analog and input, else readings fail.
// RULE_05: Read-only bit in first control register shows oscillator ramp direction.
// RULE_06: Two-bit range field in first control register picks one of three currents.
// RULE_07: Sense clock select set and first timer source clear clock first timer.
// RULE_08: Second timer source field equal to 11 clocks second timer from oscillator.
// RULE_09: Second timer off when on bit 0; free or gated when on bit 1.
// RULE_10: Software divides timer count by time base duration to get frequency.
// RULE_11: Time base never comes from the timer the oscillator is clocking.
// RULE_12: Time base best from overflow flags with second timer gate in toggle mode; no overflow flags or toggle mode here, the gate is level-only.
`timescale 1ns/1ns
`default_nettype none
`include "csc_consts.vh"
module csc_osc_control (
  input  wire        i_clock,
  input  wire        i_rstn,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  input  wire [15:0] i_sense_inputs,
  input  wire        i_osc_out,
  input  wire        i_osc_direction,
  input  wire        i_gate,
  input  wire        i_first_timer_pin_clock,
  input  wire        i_second_timer_other_clock,
  output reg         o_osc_enable,
  output reg  [1:0]  o_osc_current_range,
  output reg  [3:0]  o_sense_channel_select,
  output reg         o_osc_pad,
  output reg         o_first_timer_tick,
  output reg         o_second_timer_tick
);
  reg  [7:0]  sense_control_first;
  reg  [7:0]  sense_control_second;
  reg  [7:0]  first_timer_option;
  reg  [7:0]  second_timer_control;
  reg  [7:0]  first_timer_count;
  reg  [15:0] second_timer_count;
  reg         t0_prev;
  reg         t1_prev;
  reg  [7:0]  next_rdata;
  wire [15:0] sense_sync;
  wire        osc_sync;
  wire        dir_sync;
  wire        gate_sync;
  wire        t0_pin_sync;
  wire        t1_alt_sync;
  wire        t0_src;
  wire        t1_src;
  wire        t0_rise;
  wire        t1_rise;
  wire        t1_run;
  wire        first_timer_sense_clock_sel;
  wire        first_timer_clock_source;
  wire [1:0]  second_timer_clock_source;
  wire        second_timer_on;
  wire        second_timer_gate_enable;

  csc_sync2 u_sync_osc (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async (i_osc_out),
    .o_sync  (osc_sync)
  );
  csc_sync2 u_sync_dir (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async (i_osc_direction),
    .o_sync  (dir_sync)
  );
  csc_sync2 u_sync_gate (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async (i_gate),
    .o_sync  (gate_sync)
  );
  csc_sync2 u_sync_t0 (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async (i_first_timer_pin_clock),
    .o_sync  (t0_pin_sync)
  );
  csc_sync2 u_sync_t1 (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async (i_second_timer_other_clock),
    .o_sync  (t1_alt_sync)
  );

  // Pad levels are synchronised as well, so the routed pad output never goes
  // metastable; the price is two cycles of delay after a level change.
  genvar gi;
  generate
    for (gi = 0; gi < `CSC_NUM_INPUTS; gi = gi + 1) begin : g_sense_sync
      csc_sync2 u_sync_sense (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async (i_sense_inputs[gi]),
        .o_sync  (sense_sync[gi])
      );
    end
  endgenerate

  assign first_timer_sense_clock_sel = sense_control_first[`CSC_F1_T0_SENSE];
  assign first_timer_clock_source    = first_timer_option[`CSC_T0_CS];
  assign second_timer_clock_source   = second_timer_control[`CSC_T1_CS_HI:`CSC_T1_CS_LO];
  assign second_timer_on             = second_timer_control[`CSC_T1_ON];
  assign second_timer_gate_enable    = second_timer_control[`CSC_T1_GE];

  // The oscillator feeds the first timer only when both selections agree; the second needs only its source field at 11.
  assign t0_src = (first_timer_sense_clock_sel && !first_timer_clock_source) ?
                  osc_sync : t0_pin_sync; // RULE_07
  assign t1_src = (second_timer_clock_source == `CSC_T1_CS_SENSE) ?
                  osc_sync : t1_alt_sync; // RULE_08
  // The gated mode counts only while the synchronised gate is high.
  assign t1_run = second_timer_on && (!second_timer_gate_enable || gate_sync); // RULE_09
  assign t0_rise = t0_src && !t0_prev;
  assign t1_rise = t1_src && !t1_prev;

  // Register writes land at the strobe edge and show on the outputs one cycle later.
  // Writes to unmapped addresses are dropped without any effect.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sense_control_first  <= `CSC_RST_CTRL_FIRST;
      sense_control_second <= `CSC_RST_CTRL_SECOND;
      first_timer_option   <= `CSC_RST_T0_OPTION;
      second_timer_control <= `CSC_RST_T1_CONTROL;
    end else if (i_wr) begin
      case (i_addr)
        `CSC_ADDR_CTRL_FIRST: begin
          // The direction bit is read-only, so its stored copy is always written as zero.
          sense_control_first <= {i_wdata[7:2], 1'b0, i_wdata[0]}; // RULE_05 RULE_06
        end
        `CSC_ADDR_CTRL_SECOND: begin
          sense_control_second <= {4'h0, i_wdata[3:0]}; // RULE_02
        end
        `CSC_ADDR_T0_OPTION: begin
          first_timer_option <= i_wdata;
        end
        `CSC_ADDR_T1_CONTROL: begin
          second_timer_control <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Each timer counts rising edges of its synchronised source, so a source must
  // stay high and low for at least one clock cycle to be seen.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      t0_prev           <= 1'b0;
      first_timer_count <= 8'h00;
    end else begin
      t0_prev <= t0_src;
      // A software write of the count wins over a tick in the same cycle.
      if (i_wr && i_addr == `CSC_ADDR_T0_COUNT) begin
        first_timer_count <= i_wdata;
      end else if (t0_rise) begin
        first_timer_count <= first_timer_count + 8'h01; // RULE_07
      end
    end
  end

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      t1_prev            <= 1'b0;
      second_timer_count <= 16'h0000;
    end else begin
      t1_prev <= t1_src;
      // Only the low byte is writable, so a write also clears the high byte.
      if (i_wr && i_addr == `CSC_ADDR_T1_COUNT) begin
        second_timer_count <= {8'h00, i_wdata};
      end else if (t1_rise && t1_run) begin
        second_timer_count <= second_timer_count + 16'h0001; // RULE_09
      end
    end
  end

  // Read data is zero outside the answer cycle, so a stray read returns nothing.
  always @* begin
    next_rdata = 8'h00;
    case (i_addr)
      `CSC_ADDR_CTRL_FIRST:  next_rdata = {sense_control_first[7:2], dir_sync,
                                           sense_control_first[0]}; // RULE_05
      `CSC_ADDR_CTRL_SECOND: next_rdata = sense_control_second;
      `CSC_ADDR_T0_OPTION:   next_rdata = first_timer_option;
      `CSC_ADDR_T1_CONTROL:  next_rdata = second_timer_control;
      `CSC_ADDR_T0_COUNT:    next_rdata = first_timer_count;
      `CSC_ADDR_T1_COUNT:    next_rdata = second_timer_count[7:0];
      default:               next_rdata = 8'h00;
    endcase
  end

  // All outputs come from flip-flops, so the analog side never sees a glitch.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata                <= 8'h00;
      o_osc_enable           <= 1'b0;
      o_osc_current_range    <= `CSC_RANGE_OFF;
      o_sense_channel_select <= 4'h0;
      o_osc_pad              <= 1'b0;
      o_first_timer_tick     <= 1'b0;
      o_second_timer_tick    <= 1'b0;
    end else begin
      o_rdata             <= i_rd ? next_rdata : 8'h00;
      o_osc_enable        <= sense_control_first[`CSC_F1_ENABLE];
      o_osc_current_range <= sense_control_first[`CSC_F1_RANGE_HI:`CSC_F1_RANGE_LO]; // RULE_06
      // The mux select is registered from the register, so a new channel takes effect one cycle after it is stored.
      o_sense_channel_select <= sense_control_second[`CSC_F2_CH_HI:`CSC_F2_CH_LO]; // RULE_03
      o_osc_pad <= sense_control_first[`CSC_F1_ENABLE] &&
                   sense_sync[sense_control_second[3:0]]; // RULE_01
      o_first_timer_tick  <= t0_rise;
      o_second_timer_tick <= t1_rise && t1_run;
    end
  end
endmodule // csc_osc_control
`default_nettype wire

// *** logic/csc_sync2.v ***
`timescale 1ns/1ns
`default_nettype none
module csc_sync2 (
  input  wire i_clock,
  input  wire i_rstn,
  input  wire i_async,
  output wire o_sync
);
  reg stage_one;
  reg stage_two;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
    end else begin
      stage_one <= i_async;
      stage_two <= stage_one;
    end
  end
  assign o_sync = stage_two;
endmodule // csc_sync2
`default_nettype wire
